/* tb/gfhf_line_model.sv */
/* Transport side model: returns the framer's octets to its receive
   input and flips chosen header bits. Assumes one shared octet clock. */
`timescale 1ns/100ps
module gfhf_line_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // From the framer, and bits to flip
  input  wire logic [7:0]  line_data_i,
  input  wire logic        line_sof_i,
  input  wire logic        line_idle_i,
  input  wire logic [31:0] flip_i,
  // Back to the framer
  output logic             valid_o,
  output logic [7:0]       data_o
);
  logic [2:0] hdr_r;
  logic [2:0] pos;
  // Octet index inside the current header
  assign pos = line_sof_i ? 3'h0 : hdr_r;
  // Octets come back in sent order, header bits flipped on demand
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      valid_o <= 1'b0;
      data_o  <= 8'h00;
      hdr_r   <= 3'h4;
    end
    else
    begin
      valid_o <= valid_o | line_sof_i;
      hdr_r   <= (pos < 3'h4) ? pos + 3'h1 : pos;
      data_o  <= line_data_i ^ ((pos < 3'h4 && !line_idle_i) ? flip_i[31 - 8 * int'(pos) -: 8] : 8'h00);
    end
  end
endmodule : gfhf_line_model

/* tb/tb.sv */
/* Self-checking bench for the core header framer. Assumes the line
   model loops transmit octets back into receive. */
`timescale 1ns/100ps
module tb;
  import gfhf_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s %h %h", n, e, g); end end
  localparam logic [15:0] MAXA = GFHF_REC_MIN_AREA; // Smallest limit a receiver should take
  logic        clk_sys_i, rst_i, tx_valid_i, tx_ctrl_i, tx_ready_o, line_sof_o, line_idle_o, line_valid_i;
  logic        rx_valid_o, rx_sof_o, rx_ctrl_o, rx_corrected_o, rx_err_o;
  logic [7:0]  tx_data_i, line_data_o, line_data_i, rx_data_o;
  logic [15:0] tx_len_i, rx_len_o;
  logic [31:0] flip;
  int          mismatches, num_checks;

  // Framer with a 1600 octet limit
  gfhf_framer #(.MAX_AREA(MAXA)) uut (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .tx_valid_i     (tx_valid_i),
    .tx_data_i      (tx_data_i),
    .tx_len_i       (tx_len_i),
    .tx_ctrl_i      (tx_ctrl_i),
    .tx_ready_o     (tx_ready_o),
    .line_data_o    (line_data_o),
    .line_sof_o     (line_sof_o),
    .line_idle_o    (line_idle_o),
    .line_valid_i   (line_valid_i),
    .line_data_i    (line_data_i),
    .rx_valid_o     (rx_valid_o),
    .rx_data_o      (rx_data_o),
    .rx_sof_o       (rx_sof_o),
    .rx_len_o       (rx_len_o),
    .rx_ctrl_o      (rx_ctrl_o),
    .rx_corrected_o (rx_corrected_o),
    .rx_err_o       (rx_err_o)
  );
  // Transport loop back
  gfhf_line_model u_line (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_data_i(line_data_o), .line_sof_i(line_sof_o),
    .line_idle_i(line_idle_o), .flip_i(flip), .valid_o(line_valid_i), .data_o(line_data_i));

  // 200 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Counts, verdict, end of run
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // A bound ran out: count it and end the run
  task expire(input string n);
    mismatches++;
    $display("unexpected %s 1 0", n);
    conclude();
  endtask : expire

  // Reference check word: length times x16 modulo the generator
  function automatic logic [15:0] crc16(input logic [15:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? GFHF_CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16

  // Wait for the next header start
  task sync();
    int i;
    i = 0;
    do
    begin
      @(negedge clk_sys_i);
      i++;
    end
    while (line_sof_o !== 1'b1 && i < 80);
    if (line_sof_o !== 1'b1)
      expire("header_start");
  endtask : sync

  // Four header octets, most significant first
  task hdr(input logic [31:0] w, input logic idle);
    sync();
    `CHK("idle", idle, line_idle_o)
    for (int k = 0; k < 4; k++)
    begin
      `CHK("hdr", w[31 - 8 * k -: 8], line_data_o)
      if (idle) `CHK("ready", 1'b0, tx_ready_o)
      if (k < 3) @(negedge clk_sys_i);
    end
  endtask : hdr

  // One frame out through transmit and back through receive
  task frame(input string nm, input logic [15:0] len, input logic ctrl, input logic [31:0] fl, input bit acc,
             input bit err);
    int k, n;
    sync();
    @(posedge clk_sys_i);
    tx_valid_i <= 1'b1;
    tx_len_i <= len;
    tx_ctrl_i <= ctrl;
    tx_data_i <= 8'ha0;
    flip <= fl;
    k = 0;
    n = 0;
    fork
      begin
        hdr(acc ? {len, crc16(len)} ^ GFHF_HDR_SCRAMBLE : GFHF_HDR_SCRAMBLE, !acc);
        for (int i = 0; acc && k < len && i < 2 * len + 8; i++)
        begin
          if (tx_ready_o === 1'b1)
          begin
            k++;
            @(posedge clk_sys_i);
            tx_data_i <= 8'ha0 + k[7:0];
            if (k == len) tx_valid_i <= 1'b0;
            @(negedge clk_sys_i);
            `CHK("line", 8'h9f + k[7:0], line_data_o)
          end
          else
            @(negedge clk_sys_i);
        end
        if (acc) `CHK("taken", len, k[15:0])
        if (acc && k < len)
          expire("tx_done");
        @(posedge clk_sys_i);
        tx_valid_i <= 1'b0;
      end
      begin
        for (int i = 0; acc && i < 60 && !(rx_sof_o === 1'b1 && rx_len_o === len) && rx_err_o !== 1'b1; i++)
          @(negedge clk_sys_i);
        if (acc && !(rx_sof_o === 1'b1 && rx_len_o === len) && rx_err_o !== 1'b1)
          expire("rx_header");
        if (acc)
        begin
          `CHK("err", err, rx_err_o)
          `CHK("fix", fl != 32'h0 && !err, rx_corrected_o)
          if (!err) `CHK("len", len, rx_len_o)
          if (!err) `CHK("ctrl", len <= GFHF_CTRL_MAX, rx_ctrl_o)
          for (int i = 0; !err && n < len && i < 2 * len + 8; i++)
          begin
            @(negedge clk_sys_i);
            if (rx_valid_o === 1'b1)
            begin
              `CHK("rx", 8'ha0 + n[7:0], rx_data_o)
              n++;
            end
          end
          `CHK("count", err ? 16'h0000 : len, n[15:0])
          if (!err && n < len)
            expire("rx_done");
          repeat (4)
          begin
            @(negedge clk_sys_i);
            `CHK("end", 1'b0, rx_valid_o)
          end
        end
      end
    join
    $display("done %s", nm);
  endtask : frame

  // Idle headers right after reset
  task t_idle();
    hdr(GFHF_HDR_SCRAMBLE, 1'b1);
    $display("done idle");
  endtask : t_idle

  // Shortest user payload area
  task t_user4();
    frame("user4", 16'h0004, 1'b0, 32'h0, 1, 0);
  endtask : t_user4

  // Control frame with the highest control length
  task t_ctrl3();
    frame("ctrl3", 16'h0003, 1'b1, 32'h0, 1, 0);
  endtask : t_ctrl3

  // User frame with a control length is refused
  task t_user3();
    frame("user3", 16'h0003, 1'b0, 32'h0, 0, 0);
  endtask : t_user3

  // Control frame with a user length is refused
  task t_ctrl4();
    frame("ctrl4", 16'h0004, 1'b1, 32'h0, 0, 0);
  endtask : t_ctrl4

  // Payload area at the configured limit
  task t_max();
    frame("max", MAXA, 1'b0, 32'h0, 1, 0);
  endtask : t_max

  // One octet over the limit is refused on transmit
  task t_over();
    frame("over", MAXA + 16'h0001, 1'b0, 32'h0, 0, 0);
  endtask : t_over

  // Single length bit flipped on the line is corrected
  task t_onebit();
    frame("onebit", 16'h0123, 1'b0, 32'h00010000, 1, 0);
  endtask : t_onebit

  // Length turned from 4 into 1601 with a matching check: oversize flagged
  task t_oversize();
    frame("oversize", 16'h0004, 1'b0, {16'h0645, crc16(16'h0645)}, 1, 1);
  endtask : t_oversize

  // Two check bits flipped: uncorrectable
  task t_twobit();
    frame("twobit", 16'h0010, 1'b0, 32'h00000003, 1, 1);
  endtask : t_twobit

  // Reset in mid-run clears the outputs, then framing starts over
  task t_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK("rst_sof", 1'b0, line_sof_o)
    `CHK("rst_valid", 1'b0, rx_valid_o)
    `CHK("rst_err", 1'b0, rx_err_o)
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    hdr(GFHF_HDR_SCRAMBLE, 1'b1);
    frame("reset", 16'h0004, 1'b0, 32'h0, 1, 0);
  endtask : t_reset

  // Reset, then one scenario per call
  initial
  begin
    rst_i = 1'b1;
    tx_valid_i = 1'b0;
    tx_ctrl_i = 1'b0;
    tx_data_i = 8'h00;
    tx_len_i = 16'h0000;
    flip = 32'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_idle();
    t_user4();
    t_ctrl3();
    t_user3();
    t_ctrl4();
    t_max();
    t_over();
    t_onebit();
    t_oversize();
    t_twobit();
    t_reset();
    conclude();
  end
endmodule : tb

/* verilog/gfhf_framer.sv */
/*
  Core header framer: transmit builds a 4-octet scrambled header per
  frame and inserts idle frames; receive descrambles, checks, corrects
  and tracks frame boundaries. Assumes the receiver is already aligned
  to a header boundary (delineation hunting lives elsewhere).
*/
//
// Overview of operation
// R1: Fields are most significant octet first; bit 1 is the MSB.
// R2: Octets leave and arrive most significant octet and bit first.
// R3: A frame is octet aligned: core header then payload area.
// R4: The core header is exactly four octets: length then check.
// R5: The length field counts payload area octets after the header.
// R6: Lengths 0..3 are control frames, never ordinary user frames.
// R7: Transmit check is CRC-16 over the two length octets only.
// R8: Receive check corrects single-bit errors and detects multi-bit errors.
// R9: Payload area length is between 4 and 65535 octets.
// R10: Payload area is payload header, payload field, optional check.
// R11: Receiver accepts payload areas of at least 1600 octets.
// R12: Maximum payload area size is a setting agreed by both ends.
// R13: Check uses x16+x12+x5+1, zero preset, length times x16.
// R14: Header octets are XORed with B6AB31E0 on send and receive.
// R15: Idle frame is an all-zero header, sent when nothing waits.
// R16: Next header starts exactly length octets after the header.
// R17: Flag uncorrectable header errors and oversize lengths.
`timescale 1ns/100ps
module gfhf_framer #(
  parameter logic [15:0] MAX_AREA = gfhf_pkg::GFHF_DEF_MAX_AREA
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Client payload area stream, length given with the first octet
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic [15:0] tx_len_i,
  input  wire logic        tx_ctrl_i,
  output logic             tx_ready_o,
  // Transport octet stream out
  output logic [7:0]       line_data_o,
  output logic             line_sof_o,
  output logic             line_idle_o,
  // Transport octet stream in, one octet per clock
  input  wire logic        line_valid_i,
  input  wire logic [7:0]  line_data_i,
  // Received payload area stream
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_sof_o,
  output logic [15:0]      rx_len_o,
  output logic             rx_ctrl_o,
  output logic             rx_corrected_o,
  output logic             rx_err_o
);
  import gfhf_pkg::*;

  // Transmit state
  gfhf_tx_state_t tx_state_r;
  logic [1:0]     tx_hidx_r;
  logic [31:0]    tx_hdr_r;
  logic [15:0]    tx_left_r;
  logic           tx_len_ok;
  logic [15:0]    tx_chk;
  logic           tx_idle;
  logic [31:0]    tx_hdr_nxt;

  // Lengths 0..3 only when marked control, and within the limit
  assign tx_len_ok = tx_ctrl_i ? (tx_len_i <= GFHF_CTRL_MAX)                       // R6
                               : (tx_len_i >= GFHF_MIN_AREA && tx_len_i <= MAX_AREA); // R9 R12
  // Check over the two length octets only, MSB first
  assign tx_chk = gfhf_crc8(gfhf_crc8(GFHF_CRC_INIT, tx_len_i[15:8]), tx_len_i[7:0]); // R7 R13
  // Idle header unless a legal, non-empty frame waits at header start
  assign tx_idle    = !(tx_valid_i && tx_len_ok && tx_len_i != 16'h0000);                // R15
  // Header word as it leaves, scrambled for DC balance
  assign tx_hdr_nxt = (tx_idle ? 32'h0000_0000 : {tx_len_i, tx_chk}) ^ GFHF_HDR_SCRAMBLE; // R4 R5 R14

  // Header then payload area; idle header when nothing waits
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_state_r  <= GFHF_TX_HDR;
      tx_hidx_r   <= 2'b00;
      tx_hdr_r    <= 32'h0000_0000;
      tx_left_r   <= 16'h0000;
      line_data_o <= 8'h00;
      line_sof_o  <= 1'b0;
      line_idle_o <= 1'b0;
    end
    else
    begin
      line_sof_o <= 1'b0;
      case (tx_state_r)
        GFHF_TX_HDR:
        begin
          if (tx_hidx_r == 2'b00)
          begin
            tx_hdr_r    <= tx_hdr_nxt;
            tx_left_r   <= tx_idle ? 16'h0000 : tx_len_i;            // R5
            line_data_o <= tx_hdr_nxt[31:24];                        // R1 R2
            line_sof_o  <= 1'b1;
            line_idle_o <= tx_idle;                                  // R15
          end
          else
          begin
            line_data_o <= tx_hdr_r[31 - 8 * tx_hidx_r -: 8];        // R2
          end
          tx_hidx_r <= tx_hidx_r + 2'd1;
          if (tx_hidx_r == 2'(GFHF_HDR_OCTETS - 1) && tx_left_r != 16'h0000)
          begin
            tx_state_r <= GFHF_TX_PAY;                               // R3
          end
        end
        GFHF_TX_PAY:
        begin
          line_data_o <= tx_data_i;                                  // R10
          line_idle_o <= 1'b0;
          tx_left_r   <= tx_left_r - 16'h0001;
          if (tx_left_r == 16'h0001)
          begin
            tx_state_r <= GFHF_TX_HDR;
          end
        end
        default:
        begin
          tx_state_r <= GFHF_TX_HDR;
        end
      endcase
    end
  end

  // Client octet taken each payload cycle
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      tx_ready_o <= 1'b0;
    else
      tx_ready_o <= (tx_state_r == GFHF_TX_HDR && tx_hidx_r == 2'(GFHF_HDR_OCTETS - 1) && tx_left_r != 16'h0000)
                 || (tx_state_r == GFHF_TX_PAY && tx_left_r != 16'h0001);
  end

  // Receive state
  gfhf_rx_state_t rx_state_r;
  logic [1:0]     rx_hidx_r;
  logic [23:0]    rx_shift_r;
  logic [15:0]    rx_left_r;
  logic [31:0]    rx_hdr;
  logic [15:0]    chk_len;
  logic           chk_ok;
  logic           chk_fix;
  logic           chk_bad;

  // Descramble the assembled header before the check
  assign rx_hdr = {rx_shift_r, line_data_i} ^ GFHF_HDR_SCRAMBLE;    // R14 R1

  gfhf_hdr_check u_check (
    .hdr_i       (rx_hdr),
    .len_o       (chk_len),
    .ok_o        (chk_ok),
    .corrected_o (chk_fix),
    .bad_o       (chk_bad)
  );

  // Assemble header, then count the payload area to the next header
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state_r     <= GFHF_RX_HDR;
      rx_hidx_r      <= 2'b00;
      rx_shift_r     <= 24'h00_0000;
      rx_left_r      <= 16'h0000;
      rx_valid_o     <= 1'b0;
      rx_data_o      <= 8'h00;
      rx_sof_o       <= 1'b0;
      rx_len_o       <= 16'h0000;
      rx_ctrl_o      <= 1'b0;
      rx_corrected_o <= 1'b0;
      rx_err_o       <= 1'b0;
    end
    else
    begin
      rx_valid_o     <= 1'b0;
      rx_sof_o       <= 1'b0;
      rx_corrected_o <= 1'b0;
      rx_err_o       <= 1'b0;
      if (line_valid_i)
      begin
        case (rx_state_r)
          GFHF_RX_HDR:
          begin
            rx_shift_r <= {rx_shift_r[15:0], line_data_i};
            rx_hidx_r  <= rx_hidx_r + 2'd1;
            if (rx_hidx_r == 2'(GFHF_HDR_OCTETS - 1))
            begin
              rx_len_o       <= chk_len;
              rx_ctrl_o      <= chk_ok && chk_len <= GFHF_CTRL_MAX;   // R6
              rx_corrected_o <= chk_fix;                              // R8
              rx_err_o       <= chk_bad || (chk_ok && chk_len > MAX_AREA); // R17 R11
              if (chk_ok && chk_len != 16'h0000 && chk_len <= MAX_AREA)
              begin
                rx_left_r  <= chk_len;                                // R16
                rx_state_r <= GFHF_RX_PAY;
                rx_sof_o   <= 1'b1;
              end
            end
          end
          GFHF_RX_PAY:
          begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= line_data_i;
            rx_left_r  <= rx_left_r - 16'h0001;
            if (rx_left_r == 16'h0001)
            begin
              rx_state_r <= GFHF_RX_HDR;                              // R16
            end
          end
          default:
          begin
            rx_state_r <= GFHF_RX_HDR;
          end
        endcase
      end
    end
  end

  // Idle headers start with the first octet of the scrambled all-zero header
  a_idle_header: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R15
    line_sof_o && line_idle_o |-> line_data_o == GFHF_HDR_SCRAMBLE[31:24])
    else $error("idle header first octet wrong");

  sequence s_hdr_start;
    tx_state_r == GFHF_TX_HDR && tx_hidx_r == 2'b00;
  endsequence

  a_hdr_four: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R4
    s_hdr_start |=> line_sof_o ##1 !line_sof_o [*3])
    else $error("header not four octets");

  a_user_len: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R6
    line_sof_o && !line_idle_o && tx_state_r == GFHF_TX_HDR |-> tx_left_r != 16'h0000)
    else $error("user frame without payload");

  a_rx_err: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
    line_valid_i && rx_state_r == GFHF_RX_HDR && rx_hidx_r == 2'b11 && chk_bad |=> rx_err_o)
    else $error("uncorrectable header not flagged");

  a_rx_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
    rx_sof_o |-> rx_state_r == GFHF_RX_PAY && rx_left_r == rx_len_o)
    else $error("payload count wrong");

  a_tx_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R9
    tx_state_r == GFHF_TX_PAY |-> tx_left_r <= MAX_AREA)
    else $error("payload area over limit");

  a_tx_back: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R3
    tx_state_r == GFHF_TX_PAY && tx_left_r == 16'h0001 |=> tx_state_r == GFHF_TX_HDR && tx_hidx_r == 2'b00)
    else $error("header not immediately after payload");

  a_rx_single: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
    rx_corrected_o |-> !rx_err_o || rx_len_o > MAX_AREA)
    else $error("corrected header flagged bad");
endmodule : gfhf_framer

/* verilog/gfhf_hdr_check.sv */
/*
  Combinational core header check: syndrome of the received 32-bit
  header, single-bit correction and multi-bit detection.
  Assumes the header word is already descrambled.
*/
`timescale 1ns/100ps
module gfhf_hdr_check (
  // Descrambled header, length in [31:16]
  input  wire logic [31:0] hdr_i,
  // Results
  output logic      [15:0] len_o,
  output logic             ok_o,
  output logic             corrected_o,
  output logic             bad_o
);
  import gfhf_pkg::*;

  logic [15:0] syn;
  logic [15:0] col_syn [32];

  // Syndrome of header: remainder of length times x16 xor check
  always_comb
  begin
    syn = gfhf_crc8(gfhf_crc8(GFHF_CRC_INIT, hdr_i[31:24]), hdr_i[23:16]) ^ hdr_i[15:0];
  end

  // Syndrome of each single-bit error pattern
  always_comb
  begin
    for (int b = 0; b < 32; b++)
    begin
      logic [31:0] e;
      e = 32'h0000_0000;
      e[b] = 1'b1;
      col_syn[b] = gfhf_crc8(gfhf_crc8(GFHF_CRC_INIT, e[31:24]), e[23:16]) ^ e[15:0];
    end
  end

  // Match the syndrome to one bit and flip it
  always_comb
  begin
    logic [31:0] fixed;
    logic        hit;
    fixed = hdr_i;
    hit   = 1'b0;
    for (int b = 0; b < 32; b++)
    begin
      if (syn != 16'h0000 && syn == col_syn[b])
      begin
        fixed[b] = ~hdr_i[b];
        hit      = 1'b1;
      end
    end
    len_o       = fixed[31:16];
    ok_o        = (syn == 16'h0000) || hit;                  // R8
    corrected_o = hit;
    bad_o       = (syn != 16'h0000) && !hit;                 // R8
  end
endmodule : gfhf_hdr_check

/* verilog/gfhf_pkg.sv */
/*
  Shared constants for the core header framer: header layout, check
  polynomial, scrambling word, length limits and state encodings.
  Assumes one octet-wide data path clocked by clk_sys_i.
*/
package gfhf_pkg;
  localparam int          GFHF_HDR_OCTETS    = 4;            // Core header length
  localparam logic [15:0] GFHF_CRC_POLY      = 16'h1021;     // x16+x12+x5+1
  localparam logic [15:0] GFHF_CRC_INIT      = 16'h0000;     // Zero preset
  localparam logic [31:0] GFHF_HDR_SCRAMBLE  = 32'hb6ab31e0; // DC balance word
  localparam logic [15:0] GFHF_MIN_AREA      = 16'h0004;     // Smallest user payload area
  localparam logic [15:0] GFHF_CTRL_MAX      = 16'h0003;     // Highest control length
  localparam logic [15:0] GFHF_DEF_MAX_AREA  = 16'hffff;     // Default size limit
  localparam logic [15:0] GFHF_REC_MIN_AREA  = 16'h0640;     // 1600 octets to be accepted

  typedef enum logic [1:0] {
    GFHF_TX_HDR  = 2'b00,
    GFHF_TX_PAY  = 2'b01
  } gfhf_tx_state_t;

  typedef enum logic [1:0] {
    GFHF_RX_HDR  = 2'b00,
    GFHF_RX_PAY  = 2'b01
  } gfhf_rx_state_t;

  // Serial CRC-16 over one octet, MSB first
  function automatic logic [15:0] gfhf_crc8(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ GFHF_CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : gfhf_crc8
endpackage : gfhf_pkg
